// file: hw/viq_pkg.sv
// constants, register map and state type for the vectored interrupt controller
//------------------------------------------------------------------------------
// Notes on behaviour
// - writing 1 to set-enable enables, 1 to clear-enable disables; 0 does nothing
// - reading set-enable or clear-enable returns the present enable bits
// - an asserted but disabled interrupt becomes pending, never active
// - an active interrupt stays active when disabled, until reset or return
// - no new activation of an interrupt while its enable bit is clear
// - set-pending and clear-pending write 1 to change; reads show pending bits
// - clear-pending never changes the active state of an interrupt
// - each priority is 8 bits; four fields per 32-bit priority register
// - on acceptance the handler address is fetched from the vector table
// - the vector table base is fixed and cannot be moved by software
// - at reset the main stack pointer comes from table word zero
// - handler address comes from the table word indexed by vector number
// - handler mode on entry, thread mode after reset, return only in handler
// - tick timer is a 24-bit down counter, wraps at zero, cleared by a write to its current value
// - tick counts to zero, reloads on the next clock, then decrements again
// - tick wrap flag is set whenever the counter decrements from one to zero
// - reading the tick control register clears the wrap flag
// - tick current value is not reset; undefined until written
// - reload value zero parks the counter at zero without clearing enable
//------------------------------------------------------------------------------
package viq_pkg;
  localparam int NUM_IRQ = 32;
  localparam int PRIO_W = 8;
  localparam int TICK_W = 24;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VEC_W = 6;
  localparam int FIELDS_PER_REG = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SET_ENABLE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CLR_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SET_PEND = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CLR_PEND = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PRIO_FIRST = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PRIO_LAST = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_TICK_CTRL = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_TICK_RELOAD = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_TICK_CURRENT = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_TICK_PRIO = 8'h4c;

  // tick control and status fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_INT_BIT = 1;
  localparam int CTRL_FLAG_BIT = 16;
  localparam int STAT_MODE_BIT = 8;

  // vector table layout
  localparam logic [DATA_W-1:0] VEC_BASE = 32'h0000_0000;
  localparam logic [VEC_W-1:0] MSP_WORD = 6'h00;
  localparam logic [VEC_W-1:0] TICK_VEC = 6'h0f;
  localparam logic [VEC_W-1:0] EXT_VEC_FIRST = 6'h10;

  // running priority when nothing is active, above every real level
  localparam logic [PRIO_W:0] PRIO_IDLE = 9'h100;

  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_REQ, ST_WAIT} viq_state_t;
endpackage

// file: hw/viq_top.sv
// vectored interrupt controller with system tick timer and vector fetch
module viq_top (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic [viq_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [viq_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [viq_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic [viq_pkg::NUM_IRQ-1:0] IRQ_IN,
  input wire logic EXC_RETURN,
  output logic MEM_RD,
  output logic [viq_pkg::DATA_W-1:0] MEM_ADDR,
  input wire logic [viq_pkg::DATA_W-1:0] MEM_RDATA,
  output logic [viq_pkg::DATA_W-1:0] MAIN_STACK_POINTER,
  output logic MSP_VALID,
  output logic EXC_TAKE,
  output logic [viq_pkg::VEC_W-1:0] EXC_NUM,
  output logic [viq_pkg::DATA_W-1:0] HANDLER_ADDR,
  output logic HANDLER_MODE
);
  import viq_pkg::*;

  //----------------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [NUM_IRQ-1:0] en_ff, pend_ff, act_ff;
  logic [NUM_IRQ-1:0] nxt_pend, take_mask, ret_mask;
  logic tick_pend_ff, tick_act_ff;
  logic [PRIO_W-1:0] prio_ff [NUM_IRQ];
  logic [PRIO_W-1:0] tick_prio_ff;
  logic tick_en_ff, tick_int_ff, wrap_ff;
  logic [TICK_W-1:0] cur_ff, reload_ff, nxt_cur;
  logic tick_hit;
  viq_state_t state_ff;
  logic boot_ff;
  logic mem_rd_ff, msp_valid_ff, exc_take_ff, mode_ff;
  logic [DATA_W-1:0] mem_addr_ff, msp_ff, handler_ff, rdata_ff, rd_val;
  logic [VEC_W-1:0] vec_ff, cand_vec;
  logic [PRIO_W:0] cand_pri, run_pri;
  logic [VEC_W-1:0] cand_idx, ret_idx;
  logic take_go, ret_go;
  logic wr_prio, rd_ctrl;
  logic [2:0] prio_reg;

  //----------------------------------------------------------------------------
  // reset release
  //----------------------------------------------------------------------------
  // two-stage release of the asynchronous reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  //----------------------------------------------------------------------------
  // priority resolution
  //----------------------------------------------------------------------------
  // best pending candidate and highest-urgency active exception
  always_comb begin
    cand_pri = PRIO_IDLE;
    cand_idx = VEC_W'(NUM_IRQ);
    run_pri = PRIO_IDLE;
    ret_idx = VEC_W'(NUM_IRQ);
    // tick is checked first so it wins ties against external lines
    if (tick_pend_ff) begin
      cand_pri = {1'h0, tick_prio_ff};
    end
    if (tick_act_ff) begin
      run_pri = {1'h0, tick_prio_ff};
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      // disabled lines never compete; lowest number wins
      if (pend_ff[i] && en_ff[i] && {1'h0, prio_ff[i]} < cand_pri) begin
        cand_pri = {1'h0, prio_ff[i]};
        cand_idx = VEC_W'(i);
      end
      if (act_ff[i] && {1'h0, prio_ff[i]} < run_pri) begin
        run_pri = {1'h0, prio_ff[i]};
        ret_idx = VEC_W'(i);
      end
    end
  end

  // vector number of the candidate
  assign cand_vec = (cand_idx == VEC_W'(NUM_IRQ)) ? TICK_VEC
                  : EXT_VEC_FIRST + cand_idx;
  // preempt only with a strictly more urgent level
  assign take_go = (state_ff == ST_IDLE) && (cand_pri < run_pri);
  // return is honoured only in handler mode
  assign ret_go = (state_ff == ST_IDLE) && EXC_RETURN && mode_ff;

  // one-hot masks of the line being taken and the line returning
  always_comb begin
    take_mask = '0;
    ret_mask = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      take_mask[i] = take_go && (cand_idx == VEC_W'(i));
      ret_mask[i] = ret_go && (ret_idx == VEC_W'(i));
    end
  end

  //----------------------------------------------------------------------------
  // enable, pending and active state
  //----------------------------------------------------------------------------
  // write-1 set and write-1 clear of enables
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      en_ff <= '0;
    end else if (CE && REG_WR) begin
      if (REG_ADDR == OFS_SET_ENABLE) begin
        en_ff <= en_ff | REG_WDATA;
      end else if (REG_ADDR == OFS_CLR_ENABLE) begin
        en_ff <= en_ff & ~REG_WDATA;
      end
    end
  end

  // pending update; an asserted line that is not active or being taken sets pending over any clear
  always_comb begin
    // taking a line clears it first, so a set in the same cycle still lands
    nxt_pend = pend_ff & ~take_mask;
    if (REG_WR && REG_ADDR == OFS_SET_PEND) begin
      nxt_pend = nxt_pend | REG_WDATA;
    end
    if (REG_WR && REG_ADDR == OFS_CLR_PEND) begin
      nxt_pend = nxt_pend & ~REG_WDATA;
    end
    // pends even while disabled
    nxt_pend = nxt_pend | (IRQ_IN & ~act_ff & ~take_mask);
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= '0;
    end else if (CE) begin
      pend_ff <= nxt_pend;
    end
  end

  // active bits: only activation and return change them
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      act_ff <= '0;
      tick_act_ff <= 1'h0;
    end else if (CE) begin
      act_ff <= (act_ff | take_mask) & ~ret_mask;
      if (take_go && cand_idx == VEC_W'(NUM_IRQ)) begin
        tick_act_ff <= 1'h1;
      end else if (ret_go && ret_idx == VEC_W'(NUM_IRQ)) begin
        tick_act_ff <= 1'h0;
      end
    end
  end

  // handler mode while anything is active, thread mode from reset
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= 1'h0;
    end else if (CE) begin
      mode_ff <= |((act_ff | take_mask) & ~ret_mask)
                 || (tick_act_ff && !(ret_go && ret_idx == VEC_W'(NUM_IRQ)))
                 || (take_go && cand_idx == VEC_W'(NUM_IRQ));
    end
  end

  //----------------------------------------------------------------------------
  // priority fields
  //----------------------------------------------------------------------------
  assign wr_prio = REG_WR && REG_ADDR >= OFS_PRIO_FIRST && REG_ADDR <= OFS_PRIO_LAST
                   && REG_ADDR[1:0] == 2'h0;
  assign prio_reg = REG_ADDR[4:2];

  // four 8-bit fields per word
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        prio_ff[i] <= '0;
      end
      tick_prio_ff <= '0;
    end else if (CE) begin
      if (wr_prio) begin
        for (int k = 0; k < FIELDS_PER_REG; k++) begin
          prio_ff[{prio_reg, 2'(k)}] <= REG_WDATA[k*PRIO_W +: PRIO_W];
        end
      end
      if (REG_WR && REG_ADDR == OFS_TICK_PRIO) begin
        tick_prio_ff <= REG_WDATA[PRIO_W-1:0];
      end
    end
  end

  //----------------------------------------------------------------------------
  // system tick timer
  //----------------------------------------------------------------------------
  // reload at zero, otherwise decrement; a write to the current value clears
  always_comb begin
    nxt_cur = cur_ff;
    if (REG_WR && REG_ADDR == OFS_TICK_CURRENT) begin
      nxt_cur = '0;
    end else if (tick_en_ff) begin
      // a zero reload keeps the counter parked at zero
      nxt_cur = (cur_ff == '0) ? reload_ff : cur_ff - TICK_W'(1);
    end
  end
  // counter moves to zero by decrement
  assign tick_hit = tick_en_ff && cur_ff == TICK_W'(1)
                    && !(REG_WR && REG_ADDR == OFS_TICK_CURRENT);

  // counter value carries no reset
  always_ff @(posedge CLK) begin
    if (CE) begin
      cur_ff <= nxt_cur;
    end
  end

  assign rd_ctrl = REG_RD && REG_ADDR == OFS_TICK_CTRL;

  // tick control, reload and wrap flag
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_en_ff <= 1'h0;
      tick_int_ff <= 1'h0;
      reload_ff <= '0;
      wrap_ff <= 1'h0;
    end else if (CE) begin
      if (REG_WR && REG_ADDR == OFS_TICK_CTRL) begin
        tick_en_ff <= REG_WDATA[CTRL_EN_BIT];
        tick_int_ff <= REG_WDATA[CTRL_INT_BIT];
      end
      if (REG_WR && REG_ADDR == OFS_TICK_RELOAD) begin
        reload_ff <= REG_WDATA[TICK_W-1:0];
      end
      // read clears, a new wrap in the same cycle wins
      if (tick_hit) begin
        wrap_ff <= 1'h1;
      end else if (rd_ctrl) begin
        wrap_ff <= 1'h0;
      end
    end
  end

  // tick exception pends on wrap when its interrupt is enabled
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_pend_ff <= 1'h0;
    end else if (CE) begin
      if (tick_hit && tick_int_ff) begin
        tick_pend_ff <= 1'h1;
      end else if (take_go && cand_idx == VEC_W'(NUM_IRQ)) begin
        tick_pend_ff <= 1'h0;
      end
    end
  end

  //----------------------------------------------------------------------------
  // vector fetch sequencer
  //----------------------------------------------------------------------------
  // stack pointer at reset, then handler address per accepted exception
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_BOOT;
      boot_ff <= 1'h1;
      mem_rd_ff <= 1'h0;
      mem_addr_ff <= '0;
      msp_ff <= '0;
      msp_valid_ff <= 1'h0;
      handler_ff <= '0;
      vec_ff <= '0;
      exc_take_ff <= 1'h0;
    end else if (CE) begin
      exc_take_ff <= 1'h0;
      unique case (state_ff)
        ST_BOOT: begin
          // fixed base, word zero
          mem_rd_ff <= 1'h1;
          mem_addr_ff <= VEC_BASE + {24'h0, MSP_WORD, 2'h0};
          state_ff <= ST_REQ;
        end
        ST_IDLE: begin
          if (take_go) begin
            // fetch the handler word for this vector
            mem_rd_ff <= 1'h1;
            mem_addr_ff <= VEC_BASE + {24'h0, cand_vec, 2'h0};
            vec_ff <= cand_vec;
            state_ff <= ST_REQ;
          end
        end
        ST_REQ: begin
          mem_rd_ff <= 1'h0;
          state_ff <= ST_WAIT;
        end
        ST_WAIT: begin
          if (boot_ff) begin
            msp_ff <= MEM_RDATA;
            msp_valid_ff <= 1'h1;
            boot_ff <= 1'h0;
          end else begin
            handler_ff <= MEM_RDATA;
            exc_take_ff <= 1'h1;
          end
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // register read port
  //----------------------------------------------------------------------------
  // read value selection, unmapped reads as zero
  always_comb begin
    rd_val = '0;
    if (REG_ADDR >= OFS_PRIO_FIRST && REG_ADDR <= OFS_PRIO_LAST
        && REG_ADDR[1:0] == 2'h0) begin
      for (int k = 0; k < FIELDS_PER_REG; k++) begin
        rd_val[k*PRIO_W +: PRIO_W] = prio_ff[{prio_reg, 2'(k)}];
      end
    end else begin
      unique case (REG_ADDR)
        OFS_SET_ENABLE, OFS_CLR_ENABLE: rd_val = en_ff;
        OFS_SET_PEND, OFS_CLR_PEND: rd_val = pend_ff;
        OFS_ACTIVE: rd_val = act_ff;
        OFS_STATUS: begin
          rd_val[VEC_W-1:0] = vec_ff;
          rd_val[STAT_MODE_BIT] = mode_ff;
        end
        OFS_TICK_CTRL: begin
          rd_val[CTRL_EN_BIT] = tick_en_ff;
          rd_val[CTRL_INT_BIT] = tick_int_ff;
          rd_val[CTRL_FLAG_BIT] = wrap_ff;
        end
        OFS_TICK_RELOAD: rd_val[TICK_W-1:0] = reload_ff;
        OFS_TICK_CURRENT: rd_val[TICK_W-1:0] = cur_ff;
        OFS_TICK_PRIO: rd_val[PRIO_W-1:0] = tick_prio_ff;
        default: rd_val = '0;
      endcase
    end
  end

  // read data stands for one cycle after the strobe
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (CE) begin
      rdata_ff <= REG_RD ? rd_val : '0;
    end
  end

  //----------------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------------
  assign REG_RDATA = rdata_ff;
  assign MEM_RD = mem_rd_ff;
  assign MEM_ADDR = mem_addr_ff;
  assign MAIN_STACK_POINTER = msp_ff;
  assign MSP_VALID = msp_valid_ff;
  assign EXC_TAKE = exc_take_ff;
  assign EXC_NUM = vec_ff;
  assign HANDLER_ADDR = handler_ff;
  assign HANDLER_MODE = mode_ff;
endmodule

// file: testbench/tb_top.sv
// self-checking testbench for the vectored interrupt controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import viq_pkg::*;
  localparam logic [31:0] HBASE = 32'h0800_0000;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_IRQ-1:0] irq_in = '0;
  logic exc_return = 1'b0;
  logic mem_rd, msp_valid, exc_take, handler_mode;
  logic [DATA_W-1:0] mem_addr, mem_rdata, msp, handler_addr;
  logic [VEC_W-1:0] exc_num;
  logic [31:0] rd_q[$];
  logic [37:0] exc_q[$];
  logic rd_wait = 1'b0;
  int err_count = 0;
  int checked = 0;
  int seed = 59461;
  always #2 clk = ~clk;
  viq_top u_viq_top (.CLK(clk), .ARST_N(arst_n), .CE(ce), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .IRQ_IN(irq_in), .EXC_RETURN(exc_return), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr),
    .MEM_RDATA(mem_rdata), .MAIN_STACK_POINTER(msp), .MSP_VALID(msp_valid),
    .EXC_TAKE(exc_take), .EXC_NUM(exc_num), .HANDLER_ADDR(handler_addr),
    .HANDLER_MODE(handler_mode));
  viq_mem_model #(.HBASE(HBASE)) u_viq_mem_model (.clk(clk), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata));
  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic exp_take(input logic [5:0] v);
    exc_q.push_back({v, HBASE | {24'h0, v, 2'b00}});
  endtask
  task automatic wait_take();
    int n;
    n = 0;
    while (exc_take !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n == 100) err_count++;
    @(posedge clk);
  endtask
  task automatic ret();
    @(posedge clk);
    exc_return <= 1'b1;
    @(posedge clk);
    exc_return <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // monitor: oldest note is compared when a result appears
  always @(negedge clk) begin
    if (rd_wait) chk("read data", reg_rdata, rd_q.pop_front());
    rd_wait = reg_rd;
    if (exc_take === 1'b1) begin
      if (exc_q.size() == 0) begin
        chk("unexpected take", 32'h1, 32'h0);
      end else begin
        chk("vector", {26'h0, exc_num}, {26'h0, exc_q[0][37:32]});
        chk("handler", handler_addr, exc_q[0][31:0]);
        void'(exc_q.pop_front());
      end
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v, m;
    logic [31:0] p [8];
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("mode after reset", {31'h0, handler_mode}, 32'h0);
    chk("stack pointer", msp, HBASE);
    chk("stack valid", {31'h0, msp_valid}, 32'h1);
    rd(8'h80, 32'h0);
    // enable bits: set, zero write, clear
    v = $random(seed);
    m = $random(seed);
    wr(OFS_SET_ENABLE, v);
    wr(OFS_SET_ENABLE, 32'h0);
    rd(OFS_CLR_ENABLE, v);
    wr(OFS_CLR_ENABLE, m);
    rd(OFS_SET_ENABLE, v & ~m);
    wr(OFS_CLR_ENABLE, '1);
    // pending bits on disabled lines
    wr(OFS_SET_PEND, m);
    rd(OFS_CLR_PEND, m);
    rd(OFS_ACTIVE, 32'h0);
    wr(OFS_CLR_PEND, '1);
    rd(OFS_SET_PEND, 32'h0);
    // priority fields
    for (int i = 0; i < 8; i++) begin
      p[i] = $random(seed);
      wr(OFS_PRIO_FIRST + 8'(4 * i), p[i]);
    end
    for (int i = 0; i < 8; i++) rd(OFS_PRIO_FIRST + 8'(4 * i), p[i]);
    // frozen clock enable, then a disabled line that asserts
    @(posedge clk);
    ce <= 1'b0;
    irq_in <= 32'h20;
    repeat (4) @(posedge clk);
    irq_in <= '0;
    ce <= 1'b1;
    rd(OFS_SET_PEND, 32'h0);
    @(posedge clk);
    irq_in[5] <= 1'b1;
    repeat (4) @(posedge clk);
    irq_in[5] <= 1'b0;
    rd(OFS_SET_PEND, 32'h20);
    rd(OFS_ACTIVE, 32'h0);
    wr(OFS_CLR_PEND, 32'h20);
    // line 7 beats line 2 on priority number
    wr(OFS_PRIO_FIRST, 32'h0040_ff00);
    wr(8'h24, 32'h10ff_ffff);
    wr(OFS_SET_PEND, 32'h84);
    exp_take(6'd23);
    wr(OFS_SET_ENABLE, 32'h84);
    wait_take();
    wr(OFS_CLR_PEND, 32'h80);
    wr(OFS_CLR_ENABLE, 32'h80);
    rd(OFS_ACTIVE, 32'h80);
    rd(OFS_STATUS, 32'h0000_0117);
    rd(OFS_SET_PEND, 32'h04);
    exp_take(6'd18);
    ret();
    wait_take();
    ret();
    repeat (2) @(posedge clk);
    chk("mode after return", {31'h0, handler_mode}, 32'h0);
    ret();
    rd(OFS_ACTIVE, 32'h0);
    // tick timer
    wr(OFS_TICK_RELOAD, '1);
    rd(OFS_TICK_RELOAD, 32'h00ff_ffff);
    wr(OFS_TICK_PRIO, 32'hffff_ff33);
    rd(OFS_TICK_PRIO, 32'h0000_0033);
    wr(OFS_TICK_CURRENT, $random(seed));
    rd(OFS_TICK_CURRENT, 32'h0);
    wr(OFS_TICK_RELOAD, 32'h0);
    wr(OFS_TICK_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    rd(OFS_TICK_CURRENT, 32'h0);
    rd(OFS_TICK_CTRL, 32'h1);
    wr(OFS_TICK_RELOAD, 32'd40);
    exp_take(TICK_VEC);
    wr(OFS_TICK_CTRL, 32'h3);
    wait_take();
    wr(OFS_TICK_CTRL, 32'h1);
    ret();
    rd(OFS_TICK_CTRL, 32'h0001_0001);
    rd(OFS_TICK_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    wrap_up();
  end
  // watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule

// file: testbench/viq_mem_model.sv
// vector table memory model answering the controller's fetches
module viq_mem_model #(
  parameter logic [31:0] HBASE = 32'h0800_0000
) (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic [viq_pkg::DATA_W-1:0] mem_addr,
  output logic [viq_pkg::DATA_W-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import viq_pkg::*;
  initial mem_rdata = 32'h5a5a_5a5a;
  // table word in the cycle after the strobe only, toggling junk otherwise
  always @(posedge clk) begin
    if (mem_rd) begin
      mem_rdata <= HBASE | mem_addr;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// file: testbench/viq_top_props.sv
// assertion checker on the ports of the interrupt controller top
module viq_top_chk (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic REG_RD,
  input wire logic [viq_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic MEM_RD,
  input wire logic [viq_pkg::DATA_W-1:0] MEM_ADDR,
  input wire logic [viq_pkg::DATA_W-1:0] MEM_RDATA,
  input wire logic [viq_pkg::DATA_W-1:0] MAIN_STACK_POINTER,
  input wire logic MSP_VALID,
  input wire logic EXC_TAKE,
  input wire logic [viq_pkg::VEC_W-1:0] EXC_NUM,
  input wire logic [viq_pkg::DATA_W-1:0] HANDLER_ADDR,
  input wire logic HANDLER_MODE
);
  timeunit 1ns;
  timeprecision 1ps;
  import viq_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ----------------------------------------------------------------
  // fetch sequences
  // ----------------------------------------------------------------
  sequence s_boot;
    !MEM_RD ##1 MSP_VALID;
  endsequence
  sequence s_entry;
    !MEM_RD ##1 EXC_TAKE;
  endsequence
  boot_fetch_a: assert property (MEM_RD && !MSP_VALID |-> (MEM_ADDR == VEC_BASE) ##1 s_boot)
    else $error("stack pointer fetch out of order");
  entry_seq_a: assert property (MEM_RD && MSP_VALID |-> HANDLER_MODE ##1 s_entry)
    else $error("handler fetch out of order");
  vec_addr_a: assert property (EXC_TAKE |-> MEM_ADDR == VEC_BASE + {24'h0, EXC_NUM, 2'b00})
    else $error("vector fetched from wrong word");
  handler_data_a: assert property (EXC_TAKE |-> HANDLER_ADDR == $past(MEM_RDATA))
    else $error("handler address not the fetched word");
  msp_value_a: assert property ($rose(MSP_VALID) |-> MAIN_STACK_POINTER == $past(MEM_RDATA))
    else $error("stack pointer not the fetched word");
  take_pulse_a: assert property (EXC_TAKE |=> !EXC_TAKE [*2])
    else $error("take pulse too long");
  take_mode_a: assert property (EXC_TAKE |-> HANDLER_MODE)
    else $error("take outside handler mode");
  take_src_a: assert property (EXC_TAKE |-> $past(MEM_RD, 2))
    else $error("take without a fetch");
  rdata_idle_a: assert property ($past(CE) && !$past(REG_RD) |-> REG_RDATA == '0)
    else $error("read data outside answer cycle");
endmodule
bind viq_top viq_top_chk u_viq_top_chk (.CLK, .ARST_N, .CE, .REG_RD, .REG_RDATA, .MEM_RD,
  .MEM_ADDR, .MEM_RDATA, .MAIN_STACK_POINTER, .MSP_VALID, .EXC_TAKE, .EXC_NUM, .HANDLER_ADDR,
  .HANDLER_MODE);
